// *** design/pem_energy_accum.sv ***
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/1ps
module pem_energy_accum
  import pem_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = pem_pkg::ZC_TIMEOUT_CYCLES,
  parameter int CNTW           = 20
)
(
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic [7:0]              s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [7:0]              s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  input  wire pem_pkg::pem_phase_t [2:0] phase_in,
  input  wire logic [2:0]              zc_pin,
  output logic                         calibration_pulse_output,
  output logic                         irq_n
);
  import pem_pkg::*;

  initial
  begin
    if (TIMEOUT_CYCLES < 1 || TIMEOUT_CYCLES >= (1 << CNTW))
      $error("pem_energy_accum: timeout does not fit counter width");
  end

  localparam logic [CNTW-1:0] TO_LIMIT = CNTW'(TIMEOUT_CYCLES);
  localparam logic [3:0]      TICK_END = 4'(SAMPLE_CYCLES - 1);

  logic [7:0]  waveform_mode_control;
  logic [7:0]  gain_configuration;
  logic [7:0]  measurement_mode_register;
  logic [7:0]  phase_combination_register;
  logic [15:0] half_cycle_count;
  logic [11:0] pulse_numerator;
  logic [IRQW-1:0] irq_status;
  logic [IRQW-1:0] irq_mask;
  logic [IRQW-1:0] irq_event;

  // Write address and data held independently until both are present
  logic [7:0]  aw_addr;
  logic        aw_full;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        w_full;
  logic        do_write;
  logic        do_read;

  assign s_axi_awready = !aw_full;
  assign s_axi_wready  = !w_full;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write      = aw_full && w_full && !s_axi_bvalid;
  assign do_read       = s_axi_arvalid && s_axi_arready;

  // Write channel capture and response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full      <= 1'b0;
      w_full       <= 1'b0;
      aw_addr      <= '0;
      w_data       <= '0;
      w_strb       <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_full <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_full      <= 1'b0;
        w_full       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        case (aw_addr)
          OFS_WAVEFORM_MODE, OFS_GAIN_CONFIG, OFS_MEAS_MODE, OFS_PHASE_COMBO,
          OFS_HALF_CYCLES, OFS_PULSE_NUM, OFS_IRQ_MASK: s_axi_bresp <= RESP_OKAY;
          default:                                      s_axi_bresp <= RESP_SLVERR;
        endcase
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Software-written configuration registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      waveform_mode_control      <= WAVEFORM_RST;
      gain_configuration         <= GAIN_RST;
      measurement_mode_register  <= MEASUREMENT_MODE_REGISTER_RST;
      phase_combination_register <= COMBO_RST;
      half_cycle_count           <= HALF_CYC_RST;
      pulse_numerator            <= PULSE_RST;
      irq_mask                   <= IRQ_MASK_RST;
    end
    else if (do_write)
    begin
      case (aw_addr)
        OFS_WAVEFORM_MODE: if (w_strb[0]) waveform_mode_control <= w_data[7:0];
        OFS_GAIN_CONFIG:   if (w_strb[0]) gain_configuration <= w_data[7:0];
        OFS_MEAS_MODE:     if (w_strb[0]) measurement_mode_register <= w_data[7:0];
        OFS_PHASE_COMBO:   if (w_strb[0]) phase_combination_register <= w_data[7:0];
        OFS_HALF_CYCLES:
        begin
          if (w_strb[0]) half_cycle_count[7:0] <= w_data[7:0];
          if (w_strb[1]) half_cycle_count[15:8] <= w_data[15:8];
        end
        OFS_PULSE_NUM:
        begin
          if (w_strb[0]) pulse_numerator[7:0] <= w_data[7:0];
          if (w_strb[1]) pulse_numerator[11:8] <= w_data[11:8];
        end
        OFS_IRQ_MASK:      if (w_strb[0]) irq_mask <= w_data[IRQW-1:0];
        default:           ;
      endcase
    end
  end

  // Sample tick every 0.4 us
  logic [3:0] tick_cnt;
  logic       tick;
  assign tick = (tick_cnt == TICK_END);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      tick_cnt <= '0;
    else
      tick_cnt <= tick ? 4'h0 : tick_cnt + 4'h1;
  end

  // Line formula currents chosen by the combination field
  pem_combo_t combo;
  logic signed [IW-1:0] line_i  [3];
  logic signed [IW-1:0] line_iq [3];
  logic signed [IW-1:0] ia, ib, ic, qa, qb, qc;
  assign combo = pem_combo_t'(phase_combination_register[COMBO_FIELD_LSB +: 2]);
  assign ia = IW'(phase_in[0].i);
  assign ib = IW'(phase_in[1].i);
  assign ic = IW'(phase_in[2].i);
  assign qa = IW'(phase_in[0].iq);
  assign qb = IW'(phase_in[1].iq);
  assign qc = IW'(phase_in[2].iq);

  always_comb
  begin
    case (combo)
      COMBO_DIFF_BOTH:
      begin
        line_i  = '{ia - ib, '0, ic - ib};
        line_iq = '{qa - qb, '0, qc - qb};
      end
      COMBO_DIFF_A:
      begin
        line_i  = '{ia - ib, '0, ic};
        line_iq = '{qa - qb, '0, qc};
      end
      default:
      begin
        line_i  = '{ia, ib, ic};
        line_iq = '{qa, qb, qc};
      end
    endcase
  end

  // Per-phase power for the total path and for the line formula
  logic signed [PW-1:0] p_tot  [3];
  logic signed [PW-1:0] p_line [3];
  logic signed [PW-1:0] q_line [3];
  for (genvar k = 0; k < 3; k++)
  begin : g_phase
    pem_phase_power #(.SWP(SW)) u_total (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .tick       (tick),
      .v          (phase_in[k].v),
      .i          (IW'(phase_in[k].i)),
      .iq         (IW'(phase_in[k].iq)),
      .p_active   (p_tot[k]),
      .p_reactive ()
    );
    pem_phase_power #(.SWP(SW)) u_line (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .tick       (tick),
      .v          (phase_in[k].v),
      .i          (line_i[k]),
      .iq         (line_iq[k]),
      .p_active   (p_line[k]),
      .p_reactive (q_line[k])
    );
  end

  function automatic logic [PW-1:0] mag(input logic signed [PW-1:0] p);
    mag = p[PW-1] ? PW'(-p) : PW'(p);
  endfunction

  // No-load suppression, applied per phase
  function automatic logic signed [PW-1:0] creep(input logic signed [PW-1:0] p, input logic on);
    creep = (on && mag(p) < CREEP_THRESHOLD) ? '0 : p;
  endfunction

  // Signed or absolute contribution of one phase
  function automatic logic signed [SUMW-1:0] contrib(input logic signed [PW-1:0] p, input logic absm);
    contrib = absm ? SUMW'(mag(p)) : SUMW'(p);
  endfunction

  logic creep_on, abs_mode, react_mode;
  logic [2:0] term_sel;
  logic signed [SUMW-1:0] tot_sum, line_act_sum, react_sum, line_add, app_add;
  logic [2:0] reverse;
  assign creep_on   = !gain_configuration[GAIN_NOCREEP_BIT];
  assign abs_mode   = gain_configuration[GAIN_ABS_BIT];
  assign react_mode = waveform_mode_control[WAV_REACTIVE_BIT];
  assign term_sel   = phase_combination_register[2:0];

  // Phase sums for the total, line active and line reactive paths
  always_comb
  begin
    tot_sum      = '0;
    reverse      = '0;
    line_act_sum = '0;
    react_sum    = '0;
    for (int k = 0; k < 3; k++)
    begin
      tot_sum = tot_sum + contrib(creep(p_tot[k], creep_on), abs_mode);
      reverse[k] = p_tot[k][PW-1] && (creep(p_tot[k], creep_on) != '0);
      if (term_sel[k])
      begin
        line_act_sum = line_act_sum + contrib(creep(p_line[k], creep_on), abs_mode || react_mode);
        react_sum    = react_sum + contrib(q_line[k], 1'b0);
      end
    end
  end
  assign line_add = react_mode ? react_sum : line_act_sum;
  assign app_add  = react_mode ? line_act_sum : '0;

  // Zero-crossing synchronisers, edge detect gated by the phase enables
  logic [2:0] zc_s1, zc_s2, zc_s3, zc_en, zc_hit;
  assign zc_en  = measurement_mode_register[MEASUREMENT_MODE_REGISTER_ZC_LSB +: 3];
  assign zc_hit = (zc_s2 ^ zc_s3) & zc_en;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      zc_s1 <= '0;
      zc_s2 <= '0;
      zc_s3 <= '0;
    end
    else
    begin
      zc_s1 <= zc_pin;
      zc_s2 <= zc_s1;
      zc_s3 <= zc_s2;
    end
  end

  // Per-phase period measurement and crossing timeout
  logic [CNTW-1:0] zc_cnt [3];
  logic [15:0]     period [3];
  logic [2:0]      zc_timeout;
  for (genvar k = 0; k < 3; k++)
  begin : g_zc
    assign zc_timeout[k] = zc_en[k] && !zc_hit[k] && (zc_cnt[k] == TO_LIMIT - 1'b1);
    always_ff @(posedge aclk)
    begin
      if (!aresetn)
      begin
        zc_cnt[k] <= '0;
        period[k] <= '0;
      end
      else if (!zc_en[k])
        zc_cnt[k] <= '0;
      else if (zc_hit[k])
      begin
        zc_cnt[k] <= '0;
        period[k] <= (zc_cnt[k] > CNTW'(16'hffff)) ? 16'hffff : zc_cnt[k][15:0];
      end
      else if (zc_cnt[k] != TO_LIMIT)
        zc_cnt[k] <= zc_cnt[k] + 1'b1;
    end
  end

  // Half-cycle window counting across the enabled phases
  logic [15:0] hc_cnt;
  logic [16:0] hc_next;
  logic [15:0] hc_limit;
  logic        window_end;
  assign hc_limit   = (half_cycle_count == '0) ? 16'h0001 : half_cycle_count;
  assign hc_next    = 17'(hc_cnt) + 17'(zc_hit[0]) + 17'(zc_hit[1]) + 17'(zc_hit[2]);
  assign window_end = (zc_hit != '0) && (hc_next >= 17'(hc_limit));
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      hc_cnt <= '0;
    else if (window_end)
      hc_cnt <= '0;
    else
      hc_cnt <= hc_next[15:0];
  end

  // Total energy accumulator with read-and-clear
  logic signed [ACCW-1:0] total_acc;
  logic signed [ACCW-1:0] total_step;
  logic                   rclr_read;
  assign total_step = tick ? ACCW'(tot_sum) : '0;
  assign rclr_read  = do_read && (s_axi_araddr == OFS_TOTAL_RCLR);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      total_acc <= '0;
    else if (rclr_read)
      total_acc <= total_step;  // Sample in the clearing cycle is kept
    else
      total_acc <= total_acc + total_step;
  end

  // Line accumulators, latched at each window end
  logic signed [ACCW-1:0] line_acc;
  logic [ACCW-1:0]        app_acc;
  logic signed [ACCW-1:0] line_step;
  logic [ACCW-1:0]        app_step;
  logic [23:0]            line_cycle_energy;
  logic [23:0]            line_cycle_apparent_energy;
  assign line_step = tick ? ACCW'(line_add) : '0;
  assign app_step  = tick ? ACCW'(app_add) : '0;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      line_acc                   <= '0;
      app_acc                    <= '0;
      line_cycle_energy          <= '0;
      line_cycle_apparent_energy <= '0;
    end
    else if (window_end)
    begin
      line_cycle_energy          <= line_acc[LINE_LSB +: 24];
      line_cycle_apparent_energy <= app_acc[LINE_LSB +: 24];
      line_acc                   <= line_step;
      app_acc                    <= app_step;
    end
    else
    begin
      line_acc <= line_acc + line_step;
      app_acc  <= app_acc + app_step;
    end
  end

  // Energy-to-frequency conversion with numerator divide
  logic [ACCW-1:0]  cf_acc;
  logic [ACCW-1:0]  cf_sum;
  logic [11:0]      cf_div;
  logic [11:0]      cf_limit;
  logic             cf_lsb;
  localparam logic [ACCW-1:0] CF_STEP = ACCW'(1) << TOTAL_LSB;
  assign cf_sum   = cf_acc + (tick ? ACCW'(mag(PW'(tot_sum >>> 2))) : '0);
  assign cf_lsb   = (cf_sum >= CF_STEP);
  assign cf_limit = (pulse_numerator == '0) ? 12'h001 : pulse_numerator;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cf_acc                   <= '0;
      cf_div                   <= '0;
      calibration_pulse_output <= 1'b0;
    end
    else
    begin
      cf_acc                   <= cf_lsb ? cf_sum - CF_STEP : cf_sum;
      calibration_pulse_output <= 1'b0;
      if (cf_lsb)
      begin
        if (cf_div + 12'h001 >= cf_limit)
        begin
          cf_div                   <= '0;
          calibration_pulse_output <= 1'b1;
        end
        else
          cf_div <= cf_div + 12'h001;
      end
    end
  end

  // Interrupt events, sticky status, read clears, set wins
  logic [2:0]  reverse_q;
  logic        half_q;
  logic        half_now;
  logic        status_read;
  assign half_now    = total_acc[ACCW-1] ^ total_acc[ACCW-2];
  assign status_read = do_read && (s_axi_araddr == OFS_IRQ_STATUS);
  always_comb
  begin
    irq_event                 = '0;
    irq_event[IRQ_LINE_DONE]  = window_end;
    irq_event[IRQ_HALF_FULL]  = half_now && !half_q;
    irq_event[IRQ_REVERSE]    = |(reverse & ~reverse_q);
    irq_event[IRQ_ZC_TIMEOUT] = |zc_timeout;
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_status <= '0;
      reverse_q  <= '0;
      half_q     <= 1'b0;
      irq_n      <= 1'b1;
    end
    else
    begin
      reverse_q  <= reverse;
      half_q     <= half_now;
      irq_status <= (status_read ? '0 : irq_status) | irq_event;
      irq_n      <= !(|(irq_status & irq_mask));
    end
  end

  // Read channel: registered data, side effects at acceptance
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end
    else if (do_read)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      case (s_axi_araddr)
        OFS_WAVEFORM_MODE: s_axi_rdata <= 32'(waveform_mode_control);
        OFS_GAIN_CONFIG:   s_axi_rdata <= 32'(gain_configuration);
        OFS_MEAS_MODE:     s_axi_rdata <= 32'(measurement_mode_register);
        OFS_PHASE_COMBO:   s_axi_rdata <= 32'(phase_combination_register);
        OFS_HALF_CYCLES:   s_axi_rdata <= 32'(half_cycle_count);
        OFS_TOTAL_PLAIN,
        OFS_TOTAL_RCLR:    s_axi_rdata <= 32'(total_acc[TOTAL_LSB +: 24]);
        OFS_LINE_ENERGY:   s_axi_rdata <= 32'(line_cycle_energy);
        OFS_LINE_APPARENT: s_axi_rdata <= 32'(line_cycle_apparent_energy);
        OFS_PULSE_NUM:     s_axi_rdata <= 32'({reverse, pulse_numerator});
        OFS_IRQ_STATUS:    s_axi_rdata <= 32'(irq_status);
        OFS_IRQ_MASK:      s_axi_rdata <= 32'(irq_mask);
        OFS_PERIOD_A:      s_axi_rdata <= 32'(period[0]);
        OFS_PERIOD_A + 8'h04: s_axi_rdata <= 32'(period[1]);
        OFS_PERIOD_A + 8'h08: s_axi_rdata <= 32'(period[2]);
        default:
        begin
          s_axi_rdata <= '0;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule

// *** design/pem_phase_power.sv ***
`timescale 1ns/1ps
module pem_phase_power
  import pem_pkg::*;
#(
  parameter int SWP = 16
)
(
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic                 tick,
  input  wire logic signed [SWP-1:0] v,
  input  wire logic signed [SWP:0]   i,
  input  wire logic signed [SWP:0]   iq,
  output logic signed [PW-1:0]       p_active,
  output logic signed [PW-1:0]       p_reactive
);

  initial
  begin
    if (SWP != SW)
      $error("pem_phase_power: sample width must match package");
  end

  logic signed [2*SWP:0] prod_p;
  logic signed [2*SWP:0] prod_q;
  logic signed [PW:0]    diff_p;
  logic signed [PW:0]    diff_q;

  // Instantaneous products scaled to the power word
  assign prod_p = v * i;
  assign prod_q = v * iq;
  assign diff_p = (PW+1)'(signed'(prod_p[2*SWP:8])) - (PW+1)'(p_active);  // Keep the sign of reverse power
  assign diff_q = (PW+1)'(signed'(prod_q[2*SWP:8])) - (PW+1)'(p_reactive);

  // First-order low-pass filters keep the dc component
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      p_active   <= '0;
      p_reactive <= '0;
    end
    else if (tick)
    begin
      p_active   <= p_active + PW'(diff_p >>> LPF_SHIFT);
      p_reactive <= p_reactive + PW'(diff_q >>> LPF_SHIFT);
    end
  end

endmodule

// *** design/pem_pkg.sv ***
// Overview of operation
// - Creep threshold on at reset; gain bit 3 disables.
// - Each phase below threshold adds no active energy; reactive sums are not suppressed.
// - Threshold is code 687 of power word.
// - Gain bit 2: absolute sum, else signed.
// - Summing mode feeds total, pulse output and line active energy; reactive sums stay signed.
// - Reverse flags show negative phases not suppressed by creep, in any mode.
// - Line-cycle accumulation always runs, no enable.
// - Mode bits 4-6 enable phase crossings, timeout, period.
// - Half-cycle count is unsigned 16-bit, up to 65535.
// - Window end sets flag; enabled flag asserts interrupt.
// - Combination field picks one of three formulas.
// - Per-term select bits include each formula term.
// - Line energy shares path, LSB four times smaller.
// - Waveform bit 5 routes reactive to line energy.
// - Reactive mode: term selects feed both line registers.
// - Active into apparent register always sums unsigned.
// - Waveform bit 5 low: line holds active energy.
// - Reactive uses shifted current, low-pass filtered product.
package pem_pkg;

  // Data widths
  localparam int SW         = 16;
  localparam int IW         = SW + 1;
  localparam int PW         = 25;
  localparam int SUMW       = PW + 2;
  localparam int ACCW       = 48;
  localparam int LPF_SHIFT  = 4;

  // Register byte offsets
  localparam logic [7:0] OFS_WAVEFORM_MODE  = 8'h0c;
  localparam logic [7:0] OFS_GAIN_CONFIG    = 8'h18;
  localparam logic [7:0] OFS_MEAS_MODE      = 8'h20;
  localparam logic [7:0] OFS_PHASE_COMBO    = 8'h24;
  localparam logic [7:0] OFS_HALF_CYCLES    = 8'h28;
  localparam logic [7:0] OFS_TOTAL_PLAIN    = 8'h2c;
  localparam logic [7:0] OFS_TOTAL_RCLR     = 8'h30;
  localparam logic [7:0] OFS_LINE_ENERGY    = 8'h34;
  localparam logic [7:0] OFS_LINE_APPARENT  = 8'h38;
  localparam logic [7:0] OFS_PULSE_NUM      = 8'h3c;
  localparam logic [7:0] OFS_IRQ_STATUS     = 8'h40;
  localparam logic [7:0] OFS_IRQ_MASK       = 8'h44;
  localparam logic [7:0] OFS_PERIOD_A       = 8'h48;

  // Field positions
  localparam int GAIN_NOCREEP_BIT  = 3;
  localparam int GAIN_ABS_BIT      = 2;
  localparam int WAV_REACTIVE_BIT  = 5;
  localparam int MEASUREMENT_MODE_REGISTER_ZC_LSB      = 4;
  localparam int COMBO_FIELD_LSB   = 6;
  localparam int REVERSE_LSB       = 12;
  localparam int TOTAL_LSB         = 24;
  localparam int LINE_LSB          = 22;

  // Interrupt status bits
  localparam int IRQ_LINE_DONE  = 0;
  localparam int IRQ_HALF_FULL  = 1;
  localparam int IRQ_REVERSE    = 2;
  localparam int IRQ_ZC_TIMEOUT = 3;
  localparam int IRQW           = 4;

  // Reset values
  localparam logic [7:0]  WAVEFORM_RST = 8'h00;
  localparam logic [7:0]  GAIN_RST     = 8'h00;
  localparam logic [7:0]  MEASUREMENT_MODE_REGISTER_RST    = 8'h70;
  localparam logic [7:0]  COMBO_RST    = 8'h07;
  localparam logic [15:0] HALF_CYC_RST = 16'h0000;
  localparam logic [11:0] PULSE_RST    = 12'h000;
  localparam logic [3:0]  IRQ_MASK_RST = 4'h0;

  // Creep threshold in power word codes
  localparam logic [PW-1:0] CREEP_THRESHOLD = 25'd687;

  // Timing
  localparam int CLK_NS            = 40;
  localparam int SAMPLE_NS         = 400;
  localparam int SAMPLE_CYCLES     = (SAMPLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int ZC_TIMEOUT_MS     = 20;
  localparam int ZC_TIMEOUT_CYCLES = ZC_TIMEOUT_MS * 1000000 / CLK_NS;

  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Phase combination formulas
  typedef enum logic [1:0] {
    COMBO_STAR      = 2'b00,
    COMBO_DIFF_BOTH = 2'b01,
    COMBO_DIFF_A    = 2'b10,
    COMBO_SPARE     = 2'b11
  } pem_combo_t;

  // Per-phase samples: voltage, current, current delayed 89 degrees
  typedef struct packed {
    logic signed [SW-1:0] v;
    logic signed [SW-1:0] i;
    logic signed [SW-1:0] iq;
  } pem_phase_t;

endpackage

// *** verif/pem_energy_accum_sva.sv ***
`timescale 1ns/1ps
module pem_energy_accum_sva (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        calibration_pulse_output,
  input wire logic        irq_n
);
  // One clock domain, quiet during reset
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_read_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("address taken while data pending");
  a_read_cause: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid))
    else $error("read data without request");
  a_write_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:3] s_axi_bvalid) else $error("write not answered");
  a_pulse_single: assert property (calibration_pulse_output |=> !calibration_pulse_output)
    else $error("pulse longer than one cycle");
  a_irq_idle_reset: assert property ($rose(aresetn) |-> irq_n)
    else $error("interrupt active after reset");
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_irq: cover property (!irq_n);
endmodule
bind pem_energy_accum pem_energy_accum_sva pem_energy_accum_sva_i (.*);

// *** verif/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  import pem_pkg::*;
  logic                  aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]            s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0]           s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]            s_axi_wstrb = 4'hf;
  logic [1:0]            s_axi_bresp, s_axi_rresp;
  logic                  s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic                  s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic                  s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  pem_phase_t [2:0]      phase_in = '0;
  logic [2:0]            zc_pin = 3'h0;
  logic                  calibration_pulse_output, irq_n;
  int                    num_errors = 0, checks = 0;
  // Bus clock, 40 ns period
  always #20 aclk = ~aclk;
  pem_energy_accum pem_energy_accum_i (.*);
  // Comparison with report
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      $display("unexpected %s: expected %h seen %h", n, e, g);
      num_errors++;
    end
  endtask
  task end_sim;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Bus write: handshakes are seen at the falling edge, acted on at the next rising one
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ha, hw, hb;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 40; n++)
    begin
      @(negedge aclk);
      ha = s_axi_awvalid & s_axi_awready;
      hw = s_axi_wvalid & s_axi_wready;
      hb = s_axi_bvalid;
      if (hb)
        chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
      @(posedge aclk);
      if (ha)
        s_axi_awvalid <= 1'b0;
      if (hw)
        s_axi_wvalid <= 1'b0;
      if (hb)
      begin
        s_axi_bready <= 1'b0;
        return;
      end
    end
    chk("timeout", 1, 0);
    end_sim();
  endtask
  // Bus read with comparison of data and response
  task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic ha, hr;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 40; n++)
    begin
      @(negedge aclk);
      ha = s_axi_arvalid & s_axi_arready;
      hr = s_axi_rvalid;
      if (hr)
      begin
        chk("rdata", e, s_axi_rdata);
        chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
      end
      @(posedge aclk);
      if (ha)
        s_axi_arvalid <= 1'b0;
      if (hr)
      begin
        s_axi_rready <= 1'b0;
        return;
      end
    end
    chk("timeout", 1, 0);
    end_sim();
  endtask
  // One half cycle on a phase crossing line
  task zc(input int p);
    repeat (6) @(posedge aclk);
    zc_pin[p] <= ~zc_pin[p];
  endtask
  task irq_is(input logic e, input int w);
    repeat (w) @(negedge aclk);
    chk("irq_n", {31'h0, e}, {31'h0, irq_n});
  endtask
  // Main sequence
  initial
  begin
    logic [31:0] d;
    int          cnt;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFS_WAVEFORM_MODE, 32'h0, RESP_OKAY);
    rd(OFS_GAIN_CONFIG, 32'h0, RESP_OKAY);
    rd(OFS_MEAS_MODE, 32'h70, RESP_OKAY);
    rd(OFS_LINE_ENERGY, 32'h0, RESP_OKAY);
    rd(8'h80, 32'h0, RESP_SLVERR);
    wr(OFS_TOTAL_PLAIN, 32'h1, RESP_SLVERR);
    wr(OFS_HALF_CYCLES, 32'hffff, RESP_OKAY);
    rd(OFS_HALF_CYCLES, 32'hffff, RESP_OKAY);
    wr(OFS_WAVEFORM_MODE, 32'h20, RESP_OKAY);
    rd(OFS_WAVEFORM_MODE, 32'h20, RESP_OKAY);
    wr(OFS_WAVEFORM_MODE, 32'h0, RESP_OKAY);
    // Every formula code, ending on code 0 with all terms on
    for (int k = 2; k >= 0; k--)
    begin
      d = (32'(k) << 6) | 32'h7;
      wr(OFS_PHASE_COMBO, d, RESP_OKAY);
      rd(OFS_PHASE_COMBO, d, RESP_OKAY);
    end
    // Line window on phase A only; phase B crossings must not count
    wr(OFS_MEAS_MODE, 32'h10, RESP_OKAY);
    wr(OFS_HALF_CYCLES, 32'h1, RESP_OKAY);
    zc(1);
    zc(1);
    rd(OFS_IRQ_STATUS, 32'h0, RESP_OKAY);
    zc(0);
    irq_is(1'b1, 10);
    rd(OFS_IRQ_STATUS, 32'h1, RESP_OKAY);
    rd(OFS_IRQ_STATUS, 32'h0, RESP_OKAY);
    wr(OFS_IRQ_MASK, 32'h1, RESP_OKAY);
    wr(OFS_HALF_CYCLES, 32'h2, RESP_OKAY);
    zc(0);
    irq_is(1'b1, 10);
    zc(0);
    irq_is(1'b0, 10);
    rd(OFS_IRQ_STATUS, 32'h1, RESP_OKAY);
    irq_is(1'b1, 4);
    // Small and large reverse power on phase A in absolute mode
    wr(OFS_GAIN_CONFIG, 32'h4, RESP_OKAY);
    phase_in[0].v <= 16'sd256;
    phase_in[0].i <= -16'sd600;
    repeat (2000) @(posedge aclk);
    rd(OFS_PULSE_NUM, 32'h0, RESP_OKAY);
    wr(OFS_GAIN_CONFIG, 32'hc, RESP_OKAY);
    rd(OFS_PULSE_NUM, 32'h1000, RESP_OKAY);
    phase_in[0].i <= -16'sd800;
    repeat (2000) @(posedge aclk);
    rd(OFS_PULSE_NUM, 32'h1000, RESP_OKAY);
    // Near full-scale reverse load: |sum|/4 per tick is 2^24/16, so 2 or 3 pulses in 40 ticks
    phase_in[0].v <= 16'sh7fff;
    phase_in[0].i <= 16'sh8000;
    repeat (2000) @(posedge aclk);
    cnt = 0;
    repeat (400)
    begin
      @(negedge aclk);
      if (calibration_pulse_output === 1'b1)
        cnt++;
    end
    chk("pulses", 1, {31'h0, cnt == 2 || cnt == 3});
    end_sim();
  end
endmodule
